// ==== hbp_pkg.sv ====
// Shared constants and types for the host bus port decode block.
// Assumes a single 125 MHz system clock and an asynchronous reset.
package hbp_pkg;

  // Widths of the multiplexed address/data bus and the register index.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int REG_IDX_W = 7;

  // Field positions inside the latched host address.
  localparam int ADDR_BYTE_BIT = 0;
  localparam int ADDR_HALF_BIT = 7;

  // Register indices below this limit concern the device as a whole.
  localparam logic [REG_IDX_W-1:0] DEV_IDX_LIMIT = 7'h10;

  // Number of peripheral channels.
  localparam int CHANNELS = 2;

  // Clock rate and the least spacing of master-mode transfers.
  localparam int CLK_PERIOD_PS = 8000;
  localparam int MASTER_GAP_CLKS = 4;
  localparam int GAP_W = 3;
  localparam logic [GAP_W-1:0] GAP_RELOAD = 3'h3;
  localparam logic [GAP_W-1:0] GAP_ZERO = 3'h0;

  // Reset values.
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [1:0] SYNC_HIGH = 2'h3;
  localparam logic [1:0] SYNC_LOW = 2'h0;

  // Host access sequencer states.
  typedef enum logic [2:0] {
    HBP_IDLE = 3'h1,
    HBP_ACCESS = 3'h2,
    HBP_FINISH = 3'h4
  } hbp_host_state_t;

endpackage : hbp_pkg

// ==== hbp_chan_handshake.sv ====
// One peripheral channel's request/acknowledge handshake.
// Assumes the pins come from outside the clock domain; both are
// synchronised here before any logic looks at them.
`timescale 1ns/1ps
module hbp_chan_handshake (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Mode and internal transfer side
  input wire logic masterMode,
  input wire logic xferReady,
  output logic xferDone,
  // Cycle request pin
  input wire logic cycleReqIn,
  output logic cycleReqOut,
  output logic cycleReqOe_n,
  // Cycle acknowledge pin
  input wire logic cycleAckIn,
  output logic cycleAckOut,
  output logic cycleAckOe_n
);

  typedef struct packed {
    logic [1:0] reqSync;
    logic [1:0] ackSync;
    logic ackPrev;
    logic reqDrive;
    logic ackDrive;
    logic [hbp_pkg::GAP_W-1:0] gap;
    logic done;
  } hbp_chan_state_t;

  hbp_chan_state_t st_r;
  hbp_chan_state_t st_nxt;

  // Direction follows the mode; an enable is low while we drive.
  assign cycleReqOe_n = masterMode;
  assign cycleAckOe_n = ~masterMode;
  assign cycleReqOut = st_r.reqDrive;
  assign cycleAckOut = st_r.ackDrive;
  assign xferDone = st_r.done;

  // Next state: master mode answers requests with spaced acks, slave
  // mode raises requests and counts the far end's acks.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.reqSync = {st_r.reqSync[0], cycleReqIn};
    st_nxt.ackSync = {st_r.ackSync[0], cycleAckIn};
    st_nxt.ackPrev = st_r.ackSync[1];
    st_nxt.done = 1'b0;
    if (st_r.gap != hbp_pkg::GAP_ZERO)
    begin
      st_nxt.gap = st_r.gap - 3'h1;
    end
    if (masterMode)
    begin
      st_nxt.reqDrive = 1'b0;
      if (st_r.ackDrive && !st_r.reqSync[1])
      begin
        st_nxt.ackDrive = 1'b0;
      end
      else if (!st_r.ackDrive && st_r.reqSync[1] && xferReady &&
               st_r.gap == hbp_pkg::GAP_ZERO)
      begin
        // The reload holds off the next ack for four clocks in all.
        st_nxt.ackDrive = 1'b1;
        st_nxt.gap = hbp_pkg::GAP_RELOAD;
        st_nxt.done = 1'b1;
      end
    end
    else
    begin
      st_nxt.ackDrive = 1'b0;
      st_nxt.gap = hbp_pkg::GAP_ZERO;
      // No spacing is imposed here, so the far end sets the pace.
      st_nxt.reqDrive = xferReady && !st_r.ackSync[1];
      st_nxt.done = st_r.ackSync[1] && !st_r.ackPrev;
    end
  end

  // State register.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule : hbp_chan_handshake

// ==== hbp_port_decode.sv ====
// Processor-side bus port: multiplexed address/data decode, wait
// control, interrupt pin and the two channel handshakes.
// Assumes a register file behind it that answers regRead/regWrite with
// regAck, and host pins that are asynchronous to clk.
//
// Summary of operation
// - Address bits 7..0 arrive on the same eight lines later used for data.
// - Address bit 0 is ignored, so even and odd byte pairs alias.
// - Device-wide registers ignore address bit 7, appearing in both halves.
// - Only eight data bits move per access; upper-byte enable is unused.
// - Cycle request is an input in master mode, driven in slave mode.
// - Cycle acknowledge is driven in master mode, an input in slave mode.
// - In master mode a channel moves at most one byte per four clocks.
// - In slave mode a channel's full handshake takes at least six clocks per byte.
// - Wait control stays active until the pending access can finish.
`timescale 1ns/1ps
module hbp_port_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Host multiplexed address/data lines
  input wire logic [hbp_pkg::ADDR_W-1:0] hostAddrDataIn,
  output logic [hbp_pkg::DATA_W-1:0] hostAddrDataOut,
  output logic hostAddrDataOe_n,
  // Host strobes
  input wire logic hostAddrStrobe,
  input wire logic hostChipSel_n,
  input wire logic hostRead_n,
  input wire logic hostWrite_n,
  // Host wait control, open drain
  output logic hostReadyOut,
  output logic hostReadyOe_n,
  // Host interrupt request, open drain
  output logic hostIrqOut,
  output logic hostIrqOe_n,
  // Register file side
  output logic [hbp_pkg::REG_IDX_W-1:0] regIndex,
  output logic regRead,
  output logic regWrite,
  output logic [hbp_pkg::DATA_W-1:0] regWrData,
  input wire logic [hbp_pkg::DATA_W-1:0] regRdData,
  input wire logic regAck,
  input wire logic irqPending,
  // Channel control side
  input wire logic [hbp_pkg::CHANNELS-1:0] chanMasterMode,
  input wire logic [hbp_pkg::CHANNELS-1:0] chanXferReady,
  output logic [hbp_pkg::CHANNELS-1:0] chanXferDone,
  // Channel A handshake pins
  input wire logic chanACycleRequestIn,
  output logic chanACycleRequestOut,
  output logic chanACycleRequestOe_n,
  input wire logic chanACycleAckIn,
  output logic chanACycleAckOut,
  output logic chanACycleAckOe_n,
  // Channel B handshake pins
  input wire logic chanBCycleRequestIn,
  output logic chanBCycleRequestOut,
  output logic chanBCycleRequestOe_n,
  input wire logic chanBCycleAckIn,
  output logic chanBCycleAckOut,
  output logic chanBCycleAckOe_n
);

  typedef struct packed {
    logic [hbp_pkg::ADDR_W-1:0] adSync1;
    logic [hbp_pkg::ADDR_W-1:0] adSync2;
    logic [1:0] aleSync;
    logic [1:0] csSync;
    logic [1:0] rdSync;
    logic [1:0] wrSync;
    logic alePrev;
    logic [hbp_pkg::ADDR_W-1:0] addr;
    hbp_pkg::hbp_host_state_t state;
    logic isRead;
    logic [hbp_pkg::REG_IDX_W-1:0] idx;
    logic rdStrobe;
    logic wrStrobe;
    logic [hbp_pkg::DATA_W-1:0] wrData;
    logic [hbp_pkg::DATA_W-1:0] rdData;
    logic drive;
    logic holdWait;
    logic irq;
  } hbp_host_reg_t;

  hbp_host_reg_t st_r;
  hbp_host_reg_t st_nxt;

  // Synchronised strobe levels, active high for readability.
  logic csOn;
  logic rdOn;
  logic wrOn;
  logic aleFell;
  logic [hbp_pkg::REG_IDX_W-1:0] rawIdx;

  assign csOn = !st_r.csSync[1];
  assign rdOn = !st_r.rdSync[1];
  assign wrOn = !st_r.wrSync[1];
  assign aleFell = st_r.alePrev && !st_r.aleSync[1];

  // Bit 0 is dropped from the index; there is no upper-byte lane.
  assign rawIdx =
    st_r.addr[hbp_pkg::ADDR_W-1:hbp_pkg::ADDR_BYTE_BIT+1];

  // Register file and pin outputs from flip-flops; the open-drain pin levels are tied low.
  assign regIndex = st_r.idx;
  assign regRead = st_r.rdStrobe;
  assign regWrite = st_r.wrStrobe;
  assign regWrData = st_r.wrData;
  assign hostAddrDataOut = st_r.rdData;
  assign hostAddrDataOe_n = !st_r.drive;
  assign hostReadyOut = 1'b0;
  assign hostReadyOe_n = !st_r.holdWait;
  assign hostIrqOut = 1'b0;
  assign hostIrqOe_n = !st_r.irq;

  // Sequencer: latch address, issue one access, hold wait until the
  // register file answers, then drive read data until the strobes drop.
  // The synchronisers cost two clocks of latency on every host edge,
  // traded for immunity to metastability on the asynchronous pins.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.adSync1 = hostAddrDataIn;
    st_nxt.adSync2 = st_r.adSync1;
    st_nxt.aleSync = {st_r.aleSync[0], hostAddrStrobe};
    st_nxt.csSync = {st_r.csSync[0], hostChipSel_n};
    st_nxt.rdSync = {st_r.rdSync[0], hostRead_n};
    st_nxt.wrSync = {st_r.wrSync[0], hostWrite_n};
    st_nxt.alePrev = st_r.aleSync[1];
    st_nxt.rdStrobe = 1'b0;
    st_nxt.wrStrobe = 1'b0;
    st_nxt.irq = irqPending;
    if (aleFell)
    begin
      st_nxt.addr = st_r.adSync2;
    end
    case (st_r.state)
      hbp_pkg::HBP_IDLE:
      begin
        st_nxt.drive = 1'b0;
        if (csOn && (rdOn || wrOn))
        begin
          // Device-wide registers lose the half-select bit.
          if ({1'b0, rawIdx[hbp_pkg::REG_IDX_W-2:0]} <
              hbp_pkg::DEV_IDX_LIMIT)
          begin
            st_nxt.idx = {1'b0, rawIdx[hbp_pkg::REG_IDX_W-2:0]};
          end
          else
          begin
            st_nxt.idx = rawIdx;
          end
          st_nxt.isRead = rdOn;
          st_nxt.rdStrobe = rdOn;
          st_nxt.wrStrobe = !rdOn;
          st_nxt.wrData = st_r.adSync2[hbp_pkg::DATA_W-1:0];
          st_nxt.holdWait = 1'b1;
          st_nxt.state = hbp_pkg::HBP_ACCESS;
        end
      end
      hbp_pkg::HBP_ACCESS:
      begin
        if (regAck)
        begin
          if (st_r.isRead)
          begin
            st_nxt.rdData = regRdData;
          end
          st_nxt.holdWait = 1'b0;
          st_nxt.drive = st_r.isRead && csOn && rdOn;
          st_nxt.state = hbp_pkg::HBP_FINISH;
        end
      end
      hbp_pkg::HBP_FINISH:
      begin
        // Release as soon as either read or select goes away.
        st_nxt.drive = st_r.isRead && csOn && rdOn;
        if (!csOn || (!rdOn && !wrOn))
        begin
          st_nxt.state = hbp_pkg::HBP_IDLE;
        end
      end
      default:
      begin
        st_nxt.drive = 1'b0;
        st_nxt.holdWait = 1'b0;
        st_nxt.state = hbp_pkg::HBP_IDLE;
      end
    endcase
  end

  // State register; synchronisers reset to the idle pin levels.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_r <= '0;
      st_r.aleSync <= hbp_pkg::SYNC_LOW;
      st_r.csSync <= hbp_pkg::SYNC_HIGH;
      st_r.rdSync <= hbp_pkg::SYNC_HIGH;
      st_r.wrSync <= hbp_pkg::SYNC_HIGH;
      st_r.state <= hbp_pkg::HBP_IDLE;
      st_r.rdData <= hbp_pkg::DATA_RST;
      st_r.wrData <= hbp_pkg::DATA_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Channel pins gathered so one generate loop serves both channels.
  logic [hbp_pkg::CHANNELS-1:0] reqIn;
  logic [hbp_pkg::CHANNELS-1:0] reqOut;
  logic [hbp_pkg::CHANNELS-1:0] reqOe_n;
  logic [hbp_pkg::CHANNELS-1:0] ackIn;
  logic [hbp_pkg::CHANNELS-1:0] ackOut;
  logic [hbp_pkg::CHANNELS-1:0] ackOe_n;

  assign reqIn = {chanBCycleRequestIn, chanACycleRequestIn};
  assign ackIn = {chanBCycleAckIn, chanACycleAckIn};
  assign chanACycleRequestOut = reqOut[0];
  assign chanACycleRequestOe_n = reqOe_n[0];
  assign chanACycleAckOut = ackOut[0];
  assign chanACycleAckOe_n = ackOe_n[0];
  assign chanBCycleRequestOut = reqOut[1];
  assign chanBCycleRequestOe_n = reqOe_n[1];
  assign chanBCycleAckOut = ackOut[1];
  assign chanBCycleAckOe_n = ackOe_n[1];

  // One handshake per channel.
  genvar ch;
  generate
    for (ch = 0; ch < hbp_pkg::CHANNELS; ch++)
    begin : g_chan
      hbp_chan_handshake u_hs (
        .clk(clk),
        .reset(reset),
        .masterMode(chanMasterMode[ch]),
        .xferReady(chanXferReady[ch]),
        .xferDone(chanXferDone[ch]),
        .cycleReqIn(reqIn[ch]),
        .cycleReqOut(reqOut[ch]),
        .cycleReqOe_n(reqOe_n[ch]),
        .cycleAckIn(ackIn[ch]),
        .cycleAckOut(ackOut[ch]),
        .cycleAckOe_n(ackOe_n[ch])
      );
    end
  endgenerate

endmodule : hbp_port_decode

// ==== hbp_port_decode_properties.sv ====
// Concurrent checks on the ports of the host bus port decode block.
// Bound to hbp_port_decode from the bench; one clock domain only.
`timescale 1ns/1ps
module hbp_port_decode_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Host side
  input wire logic hostChipSel_n,
  input wire logic hostRead_n,
  input wire logic hostWrite_n,
  input wire logic hostAddrDataOe_n,
  input wire logic hostReadyOe_n,
  // Register side
  input wire logic [hbp_pkg::REG_IDX_W-1:0] regIndex,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic regAck,
  // Channel side
  input wire logic [hbp_pkg::CHANNELS-1:0] chanMasterMode,
  input wire logic chanACycleRequestOe_n,
  input wire logic chanACycleAckOut,
  input wire logic chanACycleAckOe_n
);
  logic [2:0] sinceAck_r;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Clocks since the last acknowledge rise; saturates so idle time is safe.
  always_ff @(posedge clk or posedge reset)
    if (reset)
      sinceAck_r <= 3'h7;
    else if ($rose(chanACycleAckOut))
      sinceAck_r <= 3'h0;
    else if (sinceAck_r != 3'h7)
      sinceAck_r <= sinceAck_r + 3'h1;
  // Wait, data drive, request, index and channel relations.
  AST_WAIT_AT_READ: assert property (regRead |-> !hostReadyOe_n)
    else $error("wait not held when read issued");
  AST_WAIT_HOLD: assert property (!hostReadyOe_n && !regAck
    |=> !hostReadyOe_n)
    else $error("wait dropped before answer");
  AST_WAIT_FREE: assert property (!hostReadyOe_n && regAck
    |=> hostReadyOe_n)
    else $error("wait kept after answer");
  AST_DRIVE_ON_ACK: assert property ($fell(hostAddrDataOe_n) |->
    $past(regAck) && $rose(hostReadyOe_n) && !hostRead_n)
    else $error("lines driven without answered read");
  AST_RELEASE: assert property (hostRead_n [*4] |-> hostAddrDataOe_n)
    else $error("lines still driven after read strobe");
  AST_READ_CAUSE: assert property (regRead |->
    !$past(hostRead_n, 3) && !$past(hostChipSel_n, 3))
    else $error("read without select and strobe");
  AST_WRITE_CAUSE: assert property (regWrite |->
    !$past(hostWrite_n, 3) && !$past(hostChipSel_n, 3))
    else $error("write without select and strobe");
  AST_DEV_HALF: assert property ((regRead || regWrite) &&
    regIndex[5:0] < 6'h10 |-> !regIndex[6])
    else $error("device register index keeps upper half bit");
  AST_DIRECTION: assert property (chanACycleRequestOe_n == chanMasterMode[0]
    && chanACycleAckOe_n == !chanMasterMode[0])
    else $error("channel pin direction wrong");
  AST_MASTER_GAP: assert property ($rose(chanACycleAckOut) |->
    sinceAck_r >= 3'h3)
    else $error("master transfers closer than four clocks");
  // Main scenarios reached.
  COV_READ: cover property (regRead);
  COV_WRITE: cover property (regWrite);
  COV_ACK: cover property ($rose(chanACycleAckOut));
endmodule : hbp_port_decode_properties

// ==== hbp_host_model.sv ====
// Host processor model driving the multiplexed address/data bus.
// Assumes the device's line driver and wait output are fed back to it.
`timescale 1ns/1ps
module hbp_host_model (
  // Clock
  input wire logic clk,
  // Device feedback
  input wire logic [7:0] devData,
  input wire logic devOe_n,
  input wire logic readyOe_n,
  // Host pins
  output logic [7:0] lines,
  output logic addrStrobe = 1'b0,
  output logic chipSel_n = 1'b1,
  output logic read_n = 1'b1,
  output logic write_n = 1'b1
);
  logic [7:0] hostData = 8'h00;
  logic hostDrive = 1'b0;
  logic [7:0] lastLines = 8'h00;
  // Undriven lines flip every clock so a stale value never passes.
  assign lines = !devOe_n ? devData : hostDrive ? hostData : ~lastLines;
  // Remember the last line level.
  always @(posedge clk)
    lastLines <= lines;
  // One access: address phase, then strobes held until wait is released.
  task automatic access(input logic [7:0] addr, input logic wr,
                        input logic [7:0] wdat, input logic sel,
                        output logic [7:0] rdat, output logic ok);
    logic seen;
    seen = 1'b0;
    ok = 1'b0;
    rdat = 8'h00;
    @(posedge clk);
    addrStrobe <= 1'b1;
    hostData <= addr;
    hostDrive <= 1'b1;
    repeat (3) @(posedge clk);
    addrStrobe <= 1'b0;
    repeat (3) @(posedge clk);
    hostData <= wdat;
    hostDrive <= wr;
    chipSel_n <= !sel;
    read_n <= wr;
    write_n <= !wr;
    for (int n = 0; n < 40 && !ok; n++)
    begin
      @(posedge clk);
      if (seen && readyOe_n)
      begin
        ok = 1'b1;
        rdat = lines;
      end
      seen = seen | !readyOe_n;
    end
    chipSel_n <= 1'b1;
    read_n <= 1'b1;
    write_n <= 1'b1;
    hostDrive <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : access
endmodule : hbp_host_model

// ==== host_bus_port_decode_bench.sv ====
// Self-checking bench for the host bus port decode block.
// Holds the host model, a register file peer and two channel peers.
`timescale 1ns/1ps
module host_bus_port_decode_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] hostAddrDataIn, hostAddrDataOut, regWrData, seenData, lastWr;
  logic hostAddrDataOe_n, hostAddrStrobe, hostChipSel_n, hostRead_n;
  logic hostWrite_n, hostReadyOut, hostReadyOe_n, hostIrqOut, hostIrqOe_n;
  logic [6:0] regIndex, lastIdx;
  logic regRead, regWrite, regAck = 1'b0;
  logic [7:0] regRdData = 8'h00;
  logic [7:0] accCnt = 8'h00, doneA = 8'h00, doneB = 8'h00, riseB = 8'h00;
  logic irqPending = 1'b0;
  logic [1:0] chanMasterMode = 2'h0, chanXferReady = 2'h0, chanXferDone;
  logic chanACycleRequestIn, chanACycleRequestOut, chanACycleRequestOe_n;
  logic chanACycleAckIn, chanACycleAckOut, chanACycleAckOe_n;
  logic chanBCycleRequestIn, chanBCycleRequestOut, chanBCycleRequestOe_n;
  logic chanBCycleAckIn, chanBCycleAckOut, chanBCycleAckOe_n;
  logic pReqA = 1'b0, pAckA = 1'b0, pReqB = 1'b0, pAckB = 1'b0;
  int bad_count = 0;
  int checked = 0;
  always #4 clk = ~clk;
  // Channel pins carry the peer's level unless the device drives them.
  assign chanACycleRequestIn =
    chanACycleRequestOe_n ? pReqA : chanACycleRequestOut;
  assign chanACycleAckIn = chanACycleAckOe_n ? pAckA : chanACycleAckOut;
  assign chanBCycleRequestIn =
    chanBCycleRequestOe_n ? pReqB : chanBCycleRequestOut;
  assign chanBCycleAckIn = chanBCycleAckOe_n ? pAckB : chanBCycleAckOut;
  hbp_port_decode i_dut (.clk, .reset, .hostAddrDataIn, .hostAddrDataOut,
    .hostAddrDataOe_n, .hostAddrStrobe, .hostChipSel_n, .hostRead_n,
    .hostWrite_n, .hostReadyOut, .hostReadyOe_n, .hostIrqOut, .hostIrqOe_n,
    .regIndex, .regRead, .regWrite, .regWrData, .regRdData, .regAck,
    .irqPending, .chanMasterMode, .chanXferReady, .chanXferDone,
    .chanACycleRequestIn, .chanACycleRequestOut, .chanACycleRequestOe_n,
    .chanACycleAckIn, .chanACycleAckOut, .chanACycleAckOe_n,
    .chanBCycleRequestIn, .chanBCycleRequestOut, .chanBCycleRequestOe_n,
    .chanBCycleAckIn, .chanBCycleAckOut, .chanBCycleAckOe_n);
  hbp_host_model i_host (.clk, .devData(hostAddrDataOut),
    .devOe_n(hostAddrDataOe_n), .readyOe_n(hostReadyOe_n),
    .lines(hostAddrDataIn), .addrStrobe(hostAddrStrobe),
    .chipSel_n(hostChipSel_n), .read_n(hostRead_n), .write_n(hostWrite_n));
  // Register file peer answers one clock later; peers count transfers.
  always @(posedge clk)
  begin
    regAck <= regRead | regWrite;
    regRdData <= 8'h5a ^ {1'b0, regIndex};
    if (regRead | regWrite)
    begin
      lastIdx <= regIndex;
      lastWr <= regWrData;
      accCnt <= accCnt + 8'h01;
    end
    doneA <= doneA + {7'h00, chanXferDone[0]};
    doneB <= doneB + {7'h00, chanXferDone[1]};
    // Master peers drop the request once acknowledged; slave peers echo.
    pReqA <= chanMasterMode[0] & !chanACycleAckOut;
    pReqB <= chanMasterMode[1] & !chanBCycleAckOut;
    pAckA <= !chanMasterMode[0] & chanACycleRequestOut;
    pAckB <= !chanMasterMode[1] & chanBCycleRequestOut;
    if (!chanMasterMode[1] && !pAckB && chanBCycleRequestOut)
      riseB <= riseB + 8'h01;
  end
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // A host access whose wait release must match the select given.
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [7:0] d, input logic sel);
    logic ok;
    i_host.access(a, w, d, sel, seenData, ok);
    if (ok !== sel)
    begin
      $display("unexpected wait release: expected %b, seen %b", sel, ok);
      bad_count++;
      conclude();
    end
  endtask : xfer
  // Even and odd byte addresses reach one register and read back.
  task automatic t_alias;
    for (int i = 0; i < 2; i++)
    begin
      xfer(i ? 8'h25 : 8'h24, 1'b0, 8'h00, 1'b1);
      chk("index", 8'h12, {1'b0, lastIdx});
      chk("read data", 8'h48, seenData);
    end
  endtask : t_alias
  // Device registers alias across the halves, channel ones do not.
  task automatic t_half;
    xfer(8'h86, 1'b0, 8'h00, 1'b1);
    chk("device index", 8'h03, {1'b0, lastIdx});
    chk("device data", 8'h59, seenData);
    xfer(8'ha4, 1'b0, 8'h00, 1'b1);
    chk("channel index", 8'h52, {1'b0, lastIdx});
  endtask : t_half
  // A write moves one byte; then strobes without select do nothing.
  task automatic t_write;
    logic [7:0] n0;
    xfer(8'h31, 1'b1, 8'hc3, 1'b1);
    chk("write data", 8'hc3, lastWr);
    chk("write index", 8'h18, {1'b0, lastIdx});
    n0 = accCnt;
    xfer(8'h31, 1'b0, 8'h00, 1'b0);
    chk("accesses", n0, accCnt);
  endtask : t_write
  // Master mode: pin directions and a rate capped at one per four clocks.
  task automatic t_master;
    logic [7:0] a0, b0;
    chanMasterMode <= 2'h3;
    chanXferReady <= 2'h3;
    @(posedge clk);
    a0 = doneA;
    b0 = doneB;
    repeat (40) @(posedge clk);
    chk("req dir", 8'h01, {7'h00, chanACycleRequestOe_n});
    chk("ack dir", 8'h00, {7'h00, chanACycleAckOe_n});
    chk("rate cap", 8'h01, {7'h00, doneA - a0 <= 8'h0a});
    chk("moved", 8'h01, {7'h00, doneA != a0 && doneB != b0});
  endtask : t_master
  // Slave mode: every acknowledged byte completes.
  task automatic t_slave;
    logic [7:0] d0, r0;
    chanMasterMode <= 2'h0;
    chanXferReady <= 2'h0;
    repeat (10) @(posedge clk);
    d0 = doneB;
    r0 = riseB;
    chanXferReady <= 2'h3;
    repeat (40) @(posedge clk);
    chanXferReady <= 2'h0;
    repeat (10) @(posedge clk);
    chk("req dir", 8'h00, {7'h00, chanBCycleRequestOe_n});
    chk("ack dir", 8'h01, {7'h00, chanBCycleAckOe_n});
    chk("slave bytes", riseB - r0, doneB - d0);
    chk("slave moved", 8'h01, {7'h00, doneB != d0});
  endtask : t_slave
  // Reset, then the scenarios in turn.
  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    t_alias();
    t_half();
    t_write();
    t_master();
    t_slave();
    conclude();
  end
endmodule : host_bus_port_decode_bench
bind hbp_port_decode hbp_port_decode_properties i_props (.clk, .reset,
  .hostChipSel_n, .hostRead_n, .hostWrite_n, .hostAddrDataOe_n,
  .hostReadyOe_n, .regIndex, .regRead, .regWrite, .regAck, .chanMasterMode,
  .chanACycleRequestOe_n, .chanACycleAckOut, .chanACycleAckOe_n);
